//--- stcc_pkg.sv
// Shared constants and types for the system time counter and compare unit
`default_nettype none
package stcc_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int unsigned TIME_W = 64;
   localparam int unsigned DIV_W  = 16;

   // ************************************************************
   // Build options and reset values
   // ************************************************************
   localparam bit          INTERNAL_TIME_COUNTER_ENABLE_DEF = 1'b0;
   localparam bit          INTERNAL_COMPARE_IRQ_ENABLE_DEF  = 1'b0;
   localparam logic [15:0] TIME_TICK_DIVIDER_DEF            = 16'h0064;
   localparam logic [63:0] TIME_RESET                       = 64'h0000_0000_0000_0000;
   localparam logic [63:0] CMP_RESET                        = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] TIME_ONE                         = 64'h0000_0000_0000_0001;
   localparam logic [15:0] DIV_RESET                        = 16'h0000;
   localparam logic [15:0] DIV_ONE                          = 16'h0001;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic        wr;
      logic [63:0] value;
   } cmp_write_t;

   typedef struct packed {
      logic [63:0] time_value;
      logic        timer_irq;
   } core_time_t;

endpackage : stcc_pkg
`default_nettype wire

//--- system_time_counter_compare.sv
// System time counter with optional compare interrupt for one processor core
`default_nettype none
`timescale 1ns/10ps

// What this block does
// - An optional 64-bit free-running time counter serves as time base for the core and the system.
// - The counter is off by default and counts only when its build option enables it.
// - With the counter enabled its value is driven on the 64-bit time output.
// - With the counter disabled the core time is taken from the 64-bit time input, which the far side drives.
// - An optional 64-bit compare register, when enabled, drives the core timer interrupt from its match.
// - With compare disabled the timer interrupt input pin, driven by the far side, feeds the core timer interrupt.
// - Compare works on imported time as well as internal time, so cores sharing time get independent interrupts.
// - With counter disabled and compare enabled the interrupt is made here against the received time.
module system_time_counter_compare #(
   parameter bit          INTERNAL_TIME_COUNTER_ENABLE = stcc_pkg::INTERNAL_TIME_COUNTER_ENABLE_DEF,
   parameter bit          INTERNAL_COMPARE_IRQ_ENABLE  = stcc_pkg::INTERNAL_COMPARE_IRQ_ENABLE_DEF,
   parameter logic [15:0] TIME_TICK_DIVIDER            = stcc_pkg::TIME_TICK_DIVIDER_DEF
) (
   input  wire logic                   I_SYS_CLK,
   input  wire logic                   I_RST,
   input  wire logic [63:0]            I_TIME_COUNT_IN,
   input  wire logic                   I_EXTERNAL_TIMER_IRQ_IN,
   input  wire stcc_pkg::cmp_write_t   I_CMP_WRITE,
   output logic [63:0]                 O_TIME_COUNT_OUT,
   output logic [63:0]                 O_CMP_VALUE,
   output stcc_pkg::core_time_t        O_CORE
);
   import stcc_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   logic [TIME_W-1:0] counter;
   logic [TIME_W-1:0] core_time;
   logic [TIME_W-1:0] cmp;
   logic              irq;
   logic              irq_sync1;
   logic              irq_sync2;
   logic              irq_sync3;
   logic              ext_irq_level;

   wire               tick;
   wire               counter_on;
   wire               compare_on;
   wire [TIME_W-1:0]  next_counter;
   wire [TIME_W-1:0]  next_core_time;
   wire               cmp_hit;
   wire               ext_irq_agree;
   wire               next_irq;

   assign counter_on = INTERNAL_TIME_COUNTER_ENABLE;
   assign compare_on = INTERNAL_COMPARE_IRQ_ENABLE;

   // ************************************************************
   // Time base
   // ************************************************************
   time_tick_divider #(
      .DIVIDE    (TIME_TICK_DIVIDER)
   ) u_divider (
      .I_SYS_CLK (I_SYS_CLK),
      .I_RST     (I_RST),
      .i_enable  (counter_on),
      .o_tick    (tick)
   );

   assign next_counter = counter + TIME_ONE;

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST || !counter_on) begin
         counter <= TIME_RESET;
      end else if (tick) begin
         counter <= next_counter;
      end
   end

   // Only one time source feeds the core; the disabled one is ignored
   assign next_core_time = counter_on ? counter : I_TIME_COUNT_IN;

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         core_time        <= TIME_RESET;
         O_TIME_COUNT_OUT <= TIME_RESET;
      end else begin
         core_time        <= next_core_time;
         O_TIME_COUNT_OUT <= counter_on ? counter : TIME_RESET;
      end
   end

   // ************************************************************
   // Compare register
   // ************************************************************
   // Reset to the far future so no interrupt fires before software sets it
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         cmp <= CMP_RESET;
      end else if (I_CMP_WRITE.wr) begin
         cmp <= I_CMP_WRITE.value;
      end
   end

   // ************************************************************
   // Timer interrupt pin synchroniser
   // ************************************************************
   // The first stage feeds only the second; the level moves when stages two and three agree
   assign ext_irq_agree = (irq_sync2 == irq_sync3);

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         irq_sync1     <= 1'b0;
         irq_sync2     <= 1'b0;
         irq_sync3     <= 1'b0;
         ext_irq_level <= 1'b0;
      end else begin
         irq_sync1 <= I_EXTERNAL_TIMER_IRQ_IN;
         irq_sync2 <= irq_sync1;
         irq_sync3 <= irq_sync2;
         if (ext_irq_agree) begin
            ext_irq_level <= irq_sync3;
         end
      end
   end

   // ************************************************************
   // Interrupt selection
   // ************************************************************
   // Compare uses core_time whatever its source, so imported time works too
   assign cmp_hit  = (core_time >= cmp);
   assign next_irq = compare_on ? cmp_hit : ext_irq_level;

   // Level style: the line stays high until compare is rewritten past the time
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   assign O_CORE.time_value = core_time;
   assign O_CORE.timer_irq  = irq;
   assign O_CMP_VALUE       = cmp;

   // ************************************************************
   // Checks
   // ************************************************************
   AST_COUNT_STEP: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (counter_on && tick) |=> (counter == $past(counter) + TIME_ONE))
      else $error("time counter did not step on a tick");

   AST_COUNT_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (counter_on && !tick) |=> (counter == $past(counter)))
      else $error("time counter moved without a tick");

   AST_COUNT_OFF: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !counter_on |-> (counter == TIME_RESET && O_TIME_COUNT_OUT == TIME_RESET))
      else $error("disabled time counter is not idle");

   AST_TIME_OUT: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      counter_on |=> (O_TIME_COUNT_OUT == $past(counter)))
      else $error("time output does not follow the counter");

   AST_TIME_IN: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !counter_on |=> (O_CORE.time_value == $past(I_TIME_COUNT_IN)))
      else $error("core time does not follow the time input");

   AST_CMP_IRQ: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      compare_on |=> (O_CORE.timer_irq == ($past(core_time) >= $past(cmp))))
      else $error("timer interrupt does not match the compare result");

   // The own counter steps at most once a cycle, so a write two past the time must release the line
   AST_CMP_LATER: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (compare_on && counter_on && I_CMP_WRITE.wr && I_CMP_WRITE.value > core_time + TIME_ONE)
      |=> ##1 !O_CORE.timer_irq)
      else $error("timer interrupt not released after compare moved later");

   AST_EXT_IRQ: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (!compare_on && ext_irq_agree) |=> ##1 (O_CORE.timer_irq == $past(irq_sync3, 2)))
      else $error("timer interrupt does not follow the pin");

   AST_CMP_WRITE: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      I_CMP_WRITE.wr |=> (O_CMP_VALUE == $past(I_CMP_WRITE.value)))
      else $error("compare register missed a write");

   AST_CMP_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !I_CMP_WRITE.wr |=> (O_CMP_VALUE == $past(O_CMP_VALUE)))
      else $error("compare register changed without a write");

   // Imported time reaches the compare one edge after it stands on the input, and the timer interrupt two edges after
   AST_IMPORT_IRQ: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (compare_on && !counter_on) |=> ##1 (O_CORE.timer_irq == ($past(I_TIME_COUNT_IN, 2) >= $past(cmp))))
      else $error("timer interrupt does not follow the imported time");

   AST_CORE_TIME_OWN: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      counter_on |=> (O_CORE.time_value == $past(counter)))
      else $error("core time does not follow the own counter");

   AST_NO_TICK_OFF: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      !counter_on |-> !tick)
      else $error("divider ticks while the counter is off");

   // A divide of zero or one ticks every cycle, so only longer divides are checked
   AST_TICK_GAP: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (TIME_TICK_DIVIDER > DIV_ONE && tick) |=> !tick)
      else $error("divider ticked on two cycles in a row");

   AST_RESET_STATE: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      $past(I_RST) |-> (counter == TIME_RESET && O_CORE.time_value == TIME_RESET
                        && !O_CORE.timer_irq && O_CMP_VALUE == CMP_RESET))
      else $error("state after reset is not the reset state");

   AST_SYNC_WAIT: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (irq_sync2 != irq_sync3) |=> (ext_irq_level == $past(ext_irq_level)))
      else $error("pin level moved before the synchroniser settled");

   AST_SYNC_TAKE: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
      (irq_sync2 == irq_sync3) |=> (ext_irq_level == $past(irq_sync3)))
      else $error("pin level not taken once the synchroniser agreed");

endmodule : system_time_counter_compare
`default_nettype wire

//--- system_time_counter_compare_test.sv
// Self-checking bench for the system time counter and compare unit
`default_nettype none
`timescale 1ns/10ps
module system_time_counter_compare_test;
   import stcc_pkg::*;
   localparam logic [15:0] DIV = 16'h0003;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        irq_cmd = 1'b0;
   logic [63:0] gen_time, cnt_a, cnt_b, cnt_c, cmp_a, cmp_b, cmp_c, prev, v;
   logic        gen_irq;
   cmp_write_t  cw_a = '0, cw_b = '0, cw_c = '0;
   core_time_t  core_a, core_b, core_c;
   int          miscompares = 0;
   int          checked     = 0;

   // **********************************************************
   // Core A owns the counter, B imports it, C uses the generator
   // **********************************************************
   system_time_counter_compare #(.INTERNAL_TIME_COUNTER_ENABLE(1'b1), .INTERNAL_COMPARE_IRQ_ENABLE(1'b1),
      .TIME_TICK_DIVIDER(DIV)) i_system_time_counter_compare_a (.I_SYS_CLK(sys_clk), .I_RST(rst),
      .I_TIME_COUNT_IN(gen_time), .I_EXTERNAL_TIMER_IRQ_IN(gen_irq), .I_CMP_WRITE(cw_a),
      .O_TIME_COUNT_OUT(cnt_a), .O_CMP_VALUE(cmp_a), .O_CORE(core_a));
   system_time_counter_compare #(.INTERNAL_TIME_COUNTER_ENABLE(1'b0), .INTERNAL_COMPARE_IRQ_ENABLE(1'b1),
      .TIME_TICK_DIVIDER(DIV)) i_system_time_counter_compare_b (.I_SYS_CLK(sys_clk), .I_RST(rst),
      .I_TIME_COUNT_IN(cnt_a), .I_EXTERNAL_TIMER_IRQ_IN(gen_irq), .I_CMP_WRITE(cw_b),
      .O_TIME_COUNT_OUT(cnt_b), .O_CMP_VALUE(cmp_b), .O_CORE(core_b));
   system_time_counter_compare i_system_time_counter_compare_c (.I_SYS_CLK(sys_clk), .I_RST(rst),
      .I_TIME_COUNT_IN(gen_time), .I_EXTERNAL_TIMER_IRQ_IN(gen_irq), .I_CMP_WRITE(cw_c),
      .O_TIME_COUNT_OUT(cnt_c), .O_CMP_VALUE(cmp_c), .O_CORE(core_c));
   time_generator_model i_time_generator_model (.i_clk(sys_clk), .i_rst(rst), .i_irq_level(irq_cmd),
      .o_time(gen_time), .o_irq(gen_irq));

   always #50 sys_clk = ~sys_clk;

   // **********************************************************
   // Shared tasks
   // **********************************************************
   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask : step

   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task conclude;
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   // One-cycle write pulse to the selected cores; returns 10 ns after the taking edge
   task wr(input logic [2:0] sel, input logic [63:0] val);
      cw_a = '{sel[0], val};
      cw_b = '{sel[1], val};
      cw_c = '{sel[2], val};
      step(1);
      cw_a.wr = 1'b0;
      cw_b.wr = 1'b0;
      cw_c.wr = 1'b0;
   endtask : wr

   // **********************************************************
   // Scenarios
   // **********************************************************
   task t_reset;
      chk(cnt_a, 64'h0);
      chk(core_a.time_value, 64'h0);
      chk(core_a.timer_irq, 1'b0);
      chk(cmp_a, CMP_RESET);
      chk(cmp_b, CMP_RESET);
   endtask : t_reset

   task t_count;
      step(1);
      prev = cnt_a;
      step(30);
      chk(cnt_a - prev, 64'hA);
      chk(core_a.time_value, cnt_a);
      chk(cnt_b, 64'h0);
      chk(cnt_c, 64'h0);
   endtask : t_count

   task t_import;
      prev = cnt_a;
      repeat (8) begin
         step(1);
         chk(core_b.time_value, prev);
         chk(core_c.time_value, gen_time - 64'h1);
         prev = cnt_a;
      end
   endtask : t_import

   task t_compare;
      int n;
      v = cnt_a + 64'h5;
      wr(3'b001, v);
      chk(cmp_a, v);
      step(1);
      chk(core_a.timer_irq, 1'b0);
      n = 0;
      while (core_a.timer_irq !== 1'b1) begin
         if (n == 40) begin
            chk(core_a.timer_irq, 1'b1);
            conclude();
         end
         n++;
         step(1);
      end
      chk(core_a.time_value >= v, 1'b1);
      chk(core_b.timer_irq, 1'b0);
      step(6);
      chk(core_a.timer_irq, 1'b1);
      wr(3'b001, cnt_a + 64'h3E8);
      step(1);
      chk(core_a.timer_irq, 1'b0);
      wr(3'b110, 64'h0);
      step(1);
      chk(cmp_b, 64'h0);
      chk(cmp_c, 64'h0);
      chk(core_b.timer_irq, 1'b1);
      chk(core_c.timer_irq, 1'b0);
      chk(core_a.timer_irq, 1'b0);
   endtask : t_compare

   task t_pin;
      irq_cmd = 1'b1;
      step(7);
      chk(core_c.timer_irq, 1'b1);
      chk(core_a.timer_irq, 1'b0);
      irq_cmd = 1'b0;
      step(7);
      chk(core_c.timer_irq, 1'b0);
   endtask : t_pin

   initial begin
      step(20);
      t_reset();
      rst = 1'b0;
      t_count();
      t_import();
      t_compare();
      t_pin();
      conclude();
   end
endmodule : system_time_counter_compare_test
`default_nettype wire

//--- time_generator_model.sv
// Behavioural system time generator standing on the far side of the time unit
`default_nettype none
`timescale 1ns/10ps
module time_generator_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_irq_level,
   output logic [63:0]      o_time,
   output logic             o_irq
);
   // Time steps every cycle so that any stale sample shows at once
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_time <= 64'h0;
      end else begin
         o_time <= o_time + 64'h1;
      end
   end

   // Interrupt level is commanded by the bench, registered like real logic
   always_ff @(posedge i_clk) begin
      o_irq <= i_irq_level;
   end
endmodule : time_generator_model
`default_nettype wire

//--- time_tick_divider.sv
// Core clock divider giving a one-cycle tick enable
`default_nettype none
`timescale 1ns/10ps
module time_tick_divider #(
   parameter logic [15:0] DIVIDE = stcc_pkg::TIME_TICK_DIVIDER_DEF
) (
   input  wire logic I_SYS_CLK,
   input  wire logic I_RST,
   input  wire logic i_enable,
   output logic      o_tick
);
   import stcc_pkg::*;

   logic [DIV_W-1:0] cnt;
   wire              last_cycle;

   // A divide of zero behaves as one so the tick never stalls
   assign last_cycle = (DIVIDE <= DIV_ONE) || (cnt == DIVIDE - DIV_ONE);
   assign o_tick     = i_enable && last_cycle;

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST || !i_enable || last_cycle) begin
         cnt <= DIV_RESET;
      end else begin
         cnt <= cnt + DIV_ONE;
      end
   end

endmodule : time_tick_divider
`default_nettype wire
